//--- src/fsp_cmd_decoder.v
// Sector protection command decoder with APB status and control.
`timescale 1ns/10ps
`include "fsp_cmd_regs.vh"
module fsp_cmd_decoder #(
   parameter ADDR_W = 20,
   parameter SEC_W  = 6,
   parameter NSEC   = 64
) (
   // Clock and reset.
   input  wire              CLK,
   input  wire              ARST_N,
   // Flash bus pins.
   input  wire              WE_N,
   input  wire              OE_N,
   input  wire              CE_N,
   input  wire [ADDR_W-1:0] ADDR,
   input  wire [31:0]       DQ_IN,
   output reg  [31:0]       DQ_OUT,
   output reg               DQ_OE,
   output reg               ARRAY_READ,
   // APB slave.
   input  wire              PSEL,
   input  wire              PENABLE,
   input  wire              PWRITE,
   input  wire [7:0]        PADDR,
   input  wire [31:0]       PWDATA,
   output reg  [31:0]       PRDATA,
   output reg               PREADY,
   output reg               PSLVERR
);

   // ----------------------------------------------------------------
   // States and target kinds
   // ----------------------------------------------------------------
   localparam [2:0] S_IDLE = 3'd0;
   localparam [2:0] S_U1   = 3'd1;
   localparam [2:0] S_U2   = 3'd2;
   localparam [2:0] S_C4   = 3'd3;
   localparam [2:0] S_C5   = 3'd4;
   localparam [2:0] S_C6   = 3'd5;
   localparam [2:0] S_STAT = 3'd6;

   localparam [2:0] T_SEC  = 3'd0;
   localparam [2:0] T_SECR = 3'd1;
   localparam [2:0] T_PWL  = 3'd2;
   localparam [2:0] T_PERL = 3'd3;
   localparam [2:0] T_ALL  = 3'd4;

   localparam SW = 3 + ADDR_W + 32;

   // ----------------------------------------------------------------
   // Pin synchronisation
   // ----------------------------------------------------------------
   wire [SW-1:0] sync_q;

   fsp_pin_sync #(
      .WIDTH (SW),
      .INIT  ({3'b111, {(ADDR_W+32){1'b0}}})
   ) u_sync (
      .clk    (CLK),
      .arst_n (ARST_N),
      .d      ({WE_N, OE_N, CE_N, ADDR, DQ_IN}),
      .q      (sync_q)
   );

   wire              we_s   = sync_q[SW-1];
   wire              oe_s   = sync_q[SW-2];
   wire              ce_s   = sync_q[SW-3];
   wire [ADDR_W-1:0] addr_s = sync_q[ADDR_W+31:32];
   wire [31:0]       data_s = sync_q[31:0];

   reg we_d;
   reg oe_d;

   // Strobe rise takes a write; OE fall starts a read cycle.
   wire wr_ev = ~we_d & we_s & ~ce_s;
   wire rd_ev = oe_d & ~oe_s & ~ce_s;

   // Unlock matching ignores upper address and data bits.
   wire [11:0]      a12 = addr_s[11:0];
   wire [7:0]       d8  = data_s[7:0];
   wire [5:0]       a6  = addr_s[5:0];
   // Any address in the sector names it via its top bits.
   wire [SEC_W-1:0] sec = addr_s[ADDR_W-1 -: SEC_W];

   wire is_secr = (a6 & `FSP_LOC_MASK_X) == `FSP_LOC_SECURE;
   wire is_pwl  = (a6 & `FSP_LOC_MASK_X) == `FSP_LOC_PASS_LOCK;
   wire is_perl = (a6 & `FSP_LOC_MASK_X) == `FSP_LOC_PER_LOCK;
   wire is_all  = a6 == `FSP_LOC_NV_ALL;
   wire half    = addr_s[0];

   // ----------------------------------------------------------------
   // Protection state
   // ----------------------------------------------------------------
   reg [2:0]      state;
   reg [7:0]      cmd;
   reg [2:0]      tgt;
   reg [SEC_W-1:0] tgt_sec;
   reg [NSEC-1:0] vol_guard;
   reg [NSEC-1:0] nv_guard;
   reg            secure_guard;
   reg            password_mode_lock_bit;
   reg            persistent_mode_lock_bit;
   reg            guard_lock;
   reg [63:0]     password;
   reg [1:0]      pass_ok;
   reg [31:0]     ctrl;
   reg [7:0]      last_cmd;

   wire enable = ctrl[`FSP_CTRL_EN_BIT];

   // ----------------------------------------------------------------
   // Status read value for the current command
   // ----------------------------------------------------------------
   reg [31:0] rd_val;
   reg        rd_hit;
   reg [2:0]  rd_next;

   always @* begin
      rd_val  = 32'h0000_0000;
      rd_hit  = 1'b0;
      rd_next = state;
      if (state == S_C4 || state == S_STAT) begin
         case (cmd)
            `FSP_CMD_LOCKBIT: begin
               // Lock bit status is a single read.
               rd_hit  = is_secr | is_pwl | is_perl;
               rd_next = S_IDLE;
               if (is_secr)
                  rd_val[0] = secure_guard;
               else if (is_pwl)
                  rd_val[0] = password_mode_lock_bit;
               else
                  rd_val[0] = persistent_mode_lock_bit;
            end
            `FSP_CMD_PASS_VFY: begin
               // A locked password mode hides the value.
               rd_hit  = 1'b1;
               rd_next = S_IDLE;
               if (!password_mode_lock_bit)
                  rd_val = half ? password[63:32] : password[31:0];
            end
            `FSP_CMD_NV_STAT: begin
               rd_hit  = 1'b1;
               rd_next = S_STAT;
               rd_val[7:0] = nv_guard[sec] ? `FSP_NV_SET_ANS : `FSP_NV_CLR_ANS;
            end
            `FSP_CMD_VOL_STAT: begin
               rd_hit    = 1'b1;
               rd_next   = S_STAT;
               rd_val[1] = guard_lock;
               rd_val[0] = vol_guard[sec];
            end
            default: begin
               rd_hit = 1'b0;
            end
         endcase
      end else if (state == S_C6) begin
         rd_hit  = 1'b1;
         rd_next = S_IDLE;
         case (tgt)
            T_SECR:  rd_val[0] = secure_guard;
            T_PWL:   rd_val[0] = password_mode_lock_bit;
            T_PERL:  rd_val[0] = persistent_mode_lock_bit;
            T_ALL:   rd_val[0] = |nv_guard;
            default: rd_val[0] = nv_guard[tgt_sec];
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Command sequencer
   // ----------------------------------------------------------------
   // Enabled writes take priority; a read and a write never overlap on a
   // real bus, so the read branch runs in any cycle without an enabled write.
   always @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         we_d                     <= 1'b1;
         oe_d                     <= 1'b1;
         state                    <= S_IDLE;
         cmd                      <= 8'h00;
         tgt                      <= T_SEC;
         tgt_sec                  <= {SEC_W{1'b0}};
         vol_guard                <= {NSEC{1'b0}};
         nv_guard                 <= {NSEC{1'b0}};
         secure_guard             <= 1'b0;
         password_mode_lock_bit   <= 1'b0;
         persistent_mode_lock_bit <= 1'b0;
         guard_lock               <= 1'b0;
         password                 <= 64'h0000_0000_0000_0000;
         pass_ok                  <= 2'b00;
         last_cmd                 <= 8'h00;
         DQ_OUT                   <= 32'h0000_0000;
         DQ_OE                    <= 1'b0;
         ARRAY_READ               <= 1'b1;
      end else begin
         we_d       <= we_s;
         oe_d       <= oe_s;
         ARRAY_READ <= (state == S_IDLE) || (state == S_U1) || (state == S_U2);
         if (oe_s || ce_s)
            DQ_OE <= 1'b0;
         if (wr_ev && enable) begin
            if (d8 == `FSP_CMD_RESET) begin
               state <= S_IDLE;
            end else begin
               case (state)
                  S_IDLE: begin
                     if (a12 == `FSP_ADDR_UNLOCK1 && d8 == `FSP_DATA_UNLOCK1)
                        state <= S_U1;
                  end
                  S_U1: begin
                     if (a12 == `FSP_ADDR_UNLOCK2 && d8 == `FSP_DATA_UNLOCK2)
                        state <= S_U2;
                     else
                        state <= S_IDLE;
                  end
                  S_U2: begin
                     cmd      <= d8;
                     last_cmd <= d8;
                     state    <= S_IDLE;
                     // Bank bits above the low twelve are ignored.
                     if (a12 == `FSP_ADDR_UNLOCK1) begin
                        case (d8)
                           `FSP_CMD_LOCK_SET: guard_lock <= 1'b1;
                           `FSP_CMD_LOCKBIT,
                           `FSP_CMD_PASS_PROG,
                           `FSP_CMD_PASS_VFY,
                           `FSP_CMD_PASS_UNLK,
                           `FSP_CMD_NV_STAT,
                           `FSP_CMD_VOL_STAT,
                           `FSP_CMD_VOL_WRITE: state <= S_C4;
                           default: state <= S_IDLE;
                        endcase
                     end
                  end
                  S_C4: begin
                     state <= S_IDLE;
                     case (cmd)
                        `FSP_CMD_LOCKBIT: begin
                           if (d8 == `FSP_CMD_PROG && !is_all) begin
                              // The bit is programmed on this cycle.
                              state   <= S_C5;
                              tgt_sec <= sec;
                              if (is_secr) begin
                                 tgt          <= T_SECR;
                                 secure_guard <= 1'b1;
                              end else if (is_pwl) begin
                                 tgt                    <= T_PWL;
                                 password_mode_lock_bit <= 1'b1;
                              end else if (is_perl) begin
                                 tgt                      <= T_PERL;
                                 persistent_mode_lock_bit <= 1'b1;
                              end else begin
                                 tgt <= T_SEC;
                                 // A set guard lock freezes the non-volatile guards.
                                 if (!guard_lock)
                                    nv_guard[sec] <= 1'b1;
                              end
                           end else if (d8 == `FSP_CMD_LOCKBIT && is_all) begin
                              state <= S_C5;
                              tgt   <= T_ALL;
                              if (!guard_lock)
                                 nv_guard <= {NSEC{1'b0}};
                           end
                        end
                        `FSP_CMD_PASS_PROG: begin
                           // One half per sequence; the host repeats it.
                           if (!password_mode_lock_bit) begin
                              if (half)
                                 password[63:32] <= data_s;
                              else
                                 password[31:0] <= data_s;
                           end
                        end
                        `FSP_CMD_PASS_UNLK: begin
                           // Both halves must match before the lock clears.
                           if (pass_ok[~half] &&
                               data_s == (half ? password[63:32] : password[31:0])) begin
                              guard_lock <= 1'b0;
                              pass_ok    <= 2'b00;
                           end else begin
                              pass_ok[half] <= data_s == (half ? password[63:32] : password[31:0]);
                           end
                        end
                        `FSP_CMD_VOL_WRITE: begin
                           vol_guard[sec] <= data_s[0];
                        end
                        default: begin
                           state <= S_IDLE;
                        end
                     endcase
                  end
                  S_C5: begin
                     if (d8 == ((tgt == T_ALL) ? `FSP_CMD_ERASE_VFY : `FSP_CMD_VERIFY))
                        state <= S_C6;
                     else
                        state <= S_IDLE;
                  end
                  default: begin
                     state <= S_IDLE;
                  end
               endcase
            end
         end else if (rd_ev) begin
            if (rd_hit) begin
               DQ_OUT <= rd_val;
               DQ_OE  <= 1'b1;
               state  <= rd_next;
            end else if (state != S_IDLE) begin
               state <= S_IDLE;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------
   // One wait state keeps PRDATA and PREADY straight from flops.
   wire apb_acc = PSEL & PENABLE & ~PREADY;
   wire mapped  = (PADDR == `FSP_REG_CTRL) || (PADDR == `FSP_REG_STATUS) ||
                  (PADDR == `FSP_REG_LASTCMD);

   always @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         ctrl    <= `FSP_CTRL_RST;
         PRDATA  <= 32'h0000_0000;
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
      end else begin
         PREADY  <= apb_acc;
         PSLVERR <= apb_acc & ~mapped;
         PRDATA  <= 32'h0000_0000;
         if (apb_acc && PWRITE && PADDR == `FSP_REG_CTRL)
            ctrl <= {31'h0000_0000, PWDATA[`FSP_CTRL_EN_BIT]};
         if (apb_acc && !PWRITE) begin
            case (PADDR)
               `FSP_REG_CTRL:    PRDATA <= ctrl;
               `FSP_REG_STATUS:  PRDATA <= {22'h000000, pass_ok, guard_lock,
                                            persistent_mode_lock_bit,
                                            password_mode_lock_bit,
                                            secure_guard, 1'b0, state};
               `FSP_REG_LASTCMD: PRDATA <= {24'h000000, last_cmd};
               default:          PRDATA <= 32'h0000_0000;
            endcase
         end
      end
   end

endmodule // fsp_cmd_decoder

//--- src/fsp_cmd_regs.vh
// Constants for the sector protection command decoder.
`ifndef FSP_CMD_REGS_VH
`define FSP_CMD_REGS_VH

// ----------------------------------------------------------------
// Unlock addresses and data
// ----------------------------------------------------------------
`define FSP_ADDR_UNLOCK1  12'h555
`define FSP_ADDR_UNLOCK2  12'h2aa
`define FSP_DATA_UNLOCK1  8'haa
`define FSP_DATA_UNLOCK2  8'h55

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define FSP_CMD_RESET     8'hf0
`define FSP_CMD_LOCKBIT   8'h60
`define FSP_CMD_PROG      8'h68
`define FSP_CMD_VERIFY    8'h48
`define FSP_CMD_ERASE_VFY 8'h40
`define FSP_CMD_PASS_PROG 8'h38
`define FSP_CMD_PASS_VFY  8'hc8
`define FSP_CMD_PASS_UNLK 8'h28
`define FSP_CMD_NV_STAT   8'h90
`define FSP_CMD_LOCK_SET  8'h78
`define FSP_CMD_VOL_STAT  8'h58
`define FSP_CMD_VOL_WRITE 8'h48

// ----------------------------------------------------------------
// Low six address bit location patterns
// ----------------------------------------------------------------
`define FSP_LOC_MASK_X    6'h3b
`define FSP_LOC_SECURE    6'h1a
`define FSP_LOC_PASS_LOCK 6'h0a
`define FSP_LOC_PER_LOCK  6'h12
`define FSP_LOC_NV_ALL    6'h3a

// ----------------------------------------------------------------
// Status answers
// ----------------------------------------------------------------
`define FSP_NV_SET_ANS    8'h00
`define FSP_NV_CLR_ANS    8'h01

// ----------------------------------------------------------------
// APB register map and reset values
// ----------------------------------------------------------------
`define FSP_REG_CTRL      8'h00
`define FSP_REG_STATUS    8'h04
`define FSP_REG_LASTCMD   8'h08
`define FSP_CTRL_RST      32'h0000_0001
`define FSP_CTRL_EN_BIT   0

`endif

//--- src/fsp_pin_sync.v
// Two flip-flop synchroniser for the flash bus pins.
`timescale 1ns/10ps
module fsp_pin_sync #(
   parameter WIDTH = 8,
   parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
   // Clock and reset.
   input  wire             clk,
   input  wire             arst_n,
   // Raw and synchronised levels.
   input  wire [WIDTH-1:0] d,
   output wire [WIDTH-1:0] q
);

   reg [WIDTH-1:0] meta;
   reg [WIDTH-1:0] stable;

   // The first stage feeds only the second stage.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta   <= INIT;
         stable <= INIT;
      end else begin
         meta   <= d;
         stable <= meta;
      end
   end

   assign q = stable;

endmodule // fsp_pin_sync

//--- dv/fsp_cmd_checker.sv
// Timing checker for the sector protection command decoder.
`timescale 1ns/10ps
`include "fsp_cmd_regs.vh"
module fsp_cmd_checker #(
   parameter ADDR_W = 20,
   parameter SEC_W  = 6,
   parameter NSEC   = 64
) (
   // Clock and reset.
   input wire              CLK,
   input wire              ARST_N,
   // Flash bus pins.
   input wire              WE_N,
   input wire              OE_N,
   input wire              CE_N,
   input wire [ADDR_W-1:0] ADDR,
   input wire [31:0]       DQ_IN,
   input wire [31:0]       DQ_OUT,
   input wire              DQ_OE,
   input wire              ARRAY_READ,
   // APB slave.
   input wire              PSEL,
   input wire              PENABLE,
   input wire              PWRITE,
   input wire [7:0]        PADDR,
   input wire [31:0]       PWDATA,
   input wire [31:0]       PRDATA,
   input wire              PREADY,
   input wire              PSLVERR
);
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   // Pin strobes pass a two stage synchroniser, so pin bounds allow for it.
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!ARST_N);
   a_ready_answer: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
      else $error("ready missing after access phase");
   a_ready_pulse: assert property (PREADY |=> !PREADY)
      else $error("ready held longer than one cycle");
   a_ready_cause: assert property (PREADY |-> $past(PSEL) && $past(PENABLE))
      else $error("ready without an access phase");
   a_err_unmapped: assert property (PREADY && !(PADDR inside {`FSP_REG_CTRL, `FSP_REG_STATUS, `FSP_REG_LASTCMD})
      |-> PSLVERR && PRDATA == 32'h0)
      else $error("unmapped access not refused");
   a_err_ready: assert property (PSLVERR |-> PREADY)
      else $error("error flag outside a ready cycle");
   a_drive_cause: assert property ($rose(DQ_OE) |-> !$past(OE_N, 2) && !$past(CE_N, 2))
      else $error("data driven without a read strobe");
   a_drive_release: assert property (OE_N [*4] |-> !DQ_OE)
      else $error("data still driven after read strobe ended");
   a_reset_cmd: assert property ($rose(WE_N) && !CE_N && DQ_IN[7:0] == `FSP_CMD_RESET |-> ##[1:6] ARRAY_READ)
      else $error("reset command did not return to array read");
endmodule // fsp_cmd_checker

bind fsp_cmd_decoder fsp_cmd_checker #(.ADDR_W(ADDR_W), .SEC_W(SEC_W), .NSEC(NSEC)) i_fsp_cmd_checker (
   .CLK(CLK), .ARST_N(ARST_N), .WE_N(WE_N), .OE_N(OE_N), .CE_N(CE_N), .ADDR(ADDR), .DQ_IN(DQ_IN),
   .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE), .ARRAY_READ(ARRAY_READ), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR));

//--- dv/fsp_host_model.sv
// Host model that issues asynchronous flash bus cycles.
`timescale 1ns/10ps
module fsp_host_model #(
   parameter ADDR_W = 20
) (
   // Clock.
   input  wire               clk,
   // Flash bus pins.
   output logic              we_n,
   output logic              oe_n,
   output logic              ce_n,
   output logic [ADDR_W-1:0] addr,
   output logic [31:0]       dq_in,
   input  wire  [31:0]       dq_out,
   input  wire               dq_oe
);
   // ------------------------------------------------------------
   // Bus cycles
   // ------------------------------------------------------------
   // Idle pins, strobes inactive.
   initial begin
      we_n = 1'b1;
      oe_n = 1'b1;
      ce_n = 1'b1;
      addr = '0;
      dq_in = 32'h0;
   end

   // Stale data at the strobe fall proves data is taken at the rising edge.
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
      @(posedge clk);
      ce_n <= 1'b0;
      addr <= a;
      dq_in <= ~v;
      we_n <= 1'b0;
      repeat (2) @(posedge clk);
      dq_in <= v;
      repeat (4) @(posedge clk);
      we_n <= 1'b1;
      repeat (4) @(posedge clk);
      ce_n <= 1'b1;
      dq_in <= ~v;
      addr <= ~a;
   endtask

   // Six clocks of read strobe cover the synchroniser and output register.
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] v, output logic drv);
      @(posedge clk);
      ce_n <= 1'b0;
      addr <= a;
      @(posedge clk);
      oe_n <= 1'b0;
      repeat (6) @(posedge clk);
      v = dq_out;
      drv = dq_oe;
      oe_n <= 1'b1;
      repeat (4) @(posedge clk);
      ce_n <= 1'b1;
      addr <= ~a;
   endtask
endmodule // fsp_host_model

//--- dv/test_fsp_cmd_decoder.sv
// Self-checking testbench for the sector protection command decoder.
`timescale 1ns/10ps
`include "fsp_cmd_regs.vh"
module test_fsp_cmd_decoder;
   // ------------------------------------------------------------
   // Signals and constants
   // ------------------------------------------------------------
   localparam ADDR_W = 20;
   localparam logic [ADDR_W-1:0] S5A = 20'h1_5234, S5B = 20'h1_4007, S6 = 20'h1_8000;
   localparam logic [ADDR_W-1:0] PLOC = 20'h5_400e, SLOC = 20'h0_0012, SEC = 20'h0_001e, WP = 20'h2_403a;
   logic              clk, arst_n, we_n, oe_n, ce_n, dq_oe, array_read, oe, e;
   logic              psel, penable, pwrite, pready, pslverr;
   logic [ADDR_W-1:0] addr;
   logic [31:0]       dq_in, dq_out, prdata, pwdata, d;
   logic [7:0]        paddr;
   logic [31:0]       pw [2] = '{32'h1357_9bdf, 32'h2468_ace0};
   int                n_fail = 0, samples_checked = 0, cycles = 0;

   // Free running clock.
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   fsp_cmd_decoder #(.ADDR_W(ADDR_W)) i_fsp_cmd_decoder (
      .CLK(clk), .ARST_N(arst_n), .WE_N(we_n), .OE_N(oe_n), .CE_N(ce_n), .ADDR(addr), .DQ_IN(dq_in),
      .DQ_OUT(dq_out), .DQ_OE(dq_oe), .ARRAY_READ(array_read), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
   fsp_host_model #(.ADDR_W(ADDR_W)) host (
      .clk(clk), .we_n(we_n), .oe_n(oe_n), .ce_n(ce_n), .addr(addr), .dq_in(dq_in), .dq_out(dq_out),
      .dq_oe(dq_oe));

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
      samples_checked++;
      if (s !== x) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, x, s);
      end
   endtask

   // One APB transfer; only the bench timeout ends the wait for ready.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) begin
         @(posedge clk);
         n++;
      end
      d = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk("apb wait", n, 1);
   endtask

   // Upper address and data bits are dirty on purpose in the unlock cycles.
   task automatic unl(input logic [7:0] c);
      // Status modes end only on a write, so each command leaves them first.
      host.wr({ADDR_W{1'b0}}, {24'h0, `FSP_CMD_RESET});
      host.wr({8'ha5, `FSP_ADDR_UNLOCK1}, {24'hc3c3c3, `FSP_DATA_UNLOCK1});
      host.wr({8'h5a, `FSP_ADDR_UNLOCK2}, {24'h3c3c3c, `FSP_DATA_UNLOCK2});
      host.wr({8'hff, `FSP_ADDR_UNLOCK1}, {24'h0, c});
   endtask

   task automatic rdc(input string nm, input logic [ADDR_W-1:0] a, input logic [31:0] m, input logic [31:0] x);
      host.rd(a, d, oe);
      chk(nm, d & m, x);
      chk("drive", {31'h0, oe}, 1);
   endtask

   task automatic prog(input logic [ADDR_W-1:0] a);
      unl(`FSP_CMD_LOCKBIT);
      host.wr(a, {24'h0, `FSP_CMD_PROG});
      host.wr(a, {24'h0, `FSP_CMD_VERIFY});
   endtask

   task automatic final_report;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // A hang counts as a mismatch.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         n_fail++;
         final_report;
      end
   end

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      arst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h0;
      pwdata = 32'h0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      chk("array read", {31'h0, array_read}, 1);
      apb(1'b1, `FSP_REG_CTRL, `FSP_CTRL_RST);
      apb(1'b0, `FSP_REG_CTRL, 32'h0);
      chk("ctrl", d, `FSP_CTRL_RST);
      apb(1'b1, `FSP_REG_CTRL, 32'h0);
      unl(`FSP_CMD_NV_STAT);
      @(posedge clk);
      chk("disabled", {31'h0, array_read}, 1);
      apb(1'b1, `FSP_REG_CTRL, `FSP_CTRL_RST);
      apb(1'b0, 8'h0c, 32'h0);
      chk("unmapped", {31'h0, e}, 1);
      $display("test reset done");
      prog(S5A);
      rdc("guard verify", S5A, 1, 1);
      unl(`FSP_CMD_NV_STAT);
      @(posedge clk);
      chk("status mode", {31'h0, array_read}, 0);
      rdc("nv set", S5B, 8'hff, `FSP_NV_SET_ANS);
      rdc("nv clear", S6, 8'hff, `FSP_NV_CLR_ANS);
      rdc("nv again", S5A, 8'hff, `FSP_NV_SET_ANS);
      host.wr(S6, {24'h0, `FSP_CMD_RESET});
      @(posedge clk);
      chk("reset cmd", {31'h0, array_read}, 1);
      // Every guard is set before the bulk erase to avoid over-erasure.
      for (int s = 0; s < 64; s++) begin
         prog({s[5:0], 14'h0});
         rdc("guard all", {s[5:0], 14'h0}, 1, 1);
         if (d[0] !== 1'b1) prog({s[5:0], 14'h0});
      end
      unl(`FSP_CMD_LOCKBIT);
      host.wr(WP, {24'h0, `FSP_CMD_LOCKBIT});
      host.wr(WP, {24'h0, `FSP_CMD_ERASE_VFY});
      rdc("erase verify", WP, 1, 0);
      if (d[0] !== 1'b0) begin
         unl(`FSP_CMD_LOCKBIT);
         host.wr(WP, {24'h0, `FSP_CMD_LOCKBIT});
         host.wr(WP, {24'h0, `FSP_CMD_ERASE_VFY});
         rdc("erase retry", WP, 1, 0);
      end
      unl(`FSP_CMD_NV_STAT);
      rdc("nv erased", S5B, 8'hff, `FSP_NV_CLR_ANS);
      host.wr(S6, {24'h0, `FSP_CMD_RESET});
      host.wr({8'h0, `FSP_ADDR_UNLOCK1}, {24'h0, `FSP_DATA_UNLOCK1});
      host.wr({8'h0, `FSP_ADDR_UNLOCK2}, 32'h66);
      host.wr({8'h0, `FSP_ADDR_UNLOCK1}, {24'h0, `FSP_CMD_NV_STAT});
      host.rd(S5A, d, oe);
      chk("abandoned", {30'h0, array_read, oe}, 2);
      $display("test guards done");
      unl(`FSP_CMD_VOL_WRITE);
      host.wr(S6, 32'h1);
      unl(`FSP_CMD_VOL_STAT);
      rdc("vol set", S6, 3, 1);
      rdc("vol clear", S5A, 3, 0);
      unl(`FSP_CMD_LOCK_SET);
      unl(`FSP_CMD_VOL_STAT);
      rdc("lock set", S5A, 3, 2);
      for (int h = 0; h < 2; h++) begin
         unl(`FSP_CMD_PASS_PROG);
         host.wr(h[ADDR_W-1:0], pw[h]);
      end
      for (int h = 1; h >= 0; h--) begin
         unl(`FSP_CMD_PASS_VFY);
         rdc("password half", h[ADDR_W-1:0], 32'hffff_ffff, pw[h]);
      end
      for (int h = 0; h < 2; h++) begin
         unl(`FSP_CMD_PASS_UNLK);
         host.wr(h[ADDR_W-1:0], pw[h]);
      end
      unl(`FSP_CMD_VOL_STAT);
      rdc("lock cleared", S6, 3, 1);
      $display("test volatile and password done");
      unl(`FSP_CMD_LOCKBIT);
      rdc("password lock clear", PLOC, 1, 0);
      prog(PLOC);
      rdc("password lock verify", PLOC, 1, 1);
      prog(SEC);
      rdc("secure verify", SEC, 1, 1);
      unl(`FSP_CMD_LOCKBIT);
      rdc("persist lock", SLOC, 1, 0);
      unl(`FSP_CMD_LOCKBIT);
      rdc("password lock x", PLOC ^ 20'h4, 1, 1);
      apb(1'b0, `FSP_REG_STATUS, 32'h0);
      chk("status reg", d & 32'hf0, 32'h30);
      apb(1'b0, `FSP_REG_LASTCMD, 32'h0);
      chk("last command", d, {24'h0, `FSP_CMD_LOCKBIT});
      $display("test mode locks done");
      final_report;
   end
endmodule // test_fsp_cmd_decoder
